/* File: design/tag_writer.sv */
// Reader-side controller that builds block write commands for the tag
`timescale 1ns/10ps
`include "tag_writer_params.svh"
module tag_writer #(
  parameter int TIMEOUT = `RESP_TIMEOUT
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // User command port
  input  wire logic                   start,
  input  wire tag_writer_pkg::cmd_t   cmd,
  input  wire tag_writer_pkg::aib_t   attribute_info_block,
  // User block data loading
  input  wire logic                   buf_wr_en,
  input  wire logic [7:0]             buf_wr_addr,
  input  wire logic [7:0]             buf_wr_data,
  // Command byte stream toward the tag
  output logic                        tx_valid,
  output logic [7:0]                  tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_ready,
  // Response byte stream from the tag
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_data,
  // User results
  output logic                        busy,
  output logic                        done,
  output tag_writer_pkg::err_t        err,
  output tag_writer_pkg::status_t     status
);
  import tag_writer_pkg::*;

  state_t      state;
  cmd_t        cur;
  aib_t        cur_aib;
  logic [7:0]  cnt;
  logic        primed;
  logic [7:0]  mem_data;
  state_t      tx_seg;
  logic [7:0]  tx_idx;
  logic [3:0]  rcnt;
  logic [63:0] idm_sh;
  logic        resp_bad;
  logic [31:0] wcnt;

  // Start checks on the requested command
  wire         idle      = (state == ST_IDLE);
  wire         take      = start && idle;
  wire         ndef_mode = (cmd.mode != MODE_USER);
  wire [7:0]   m_eff     = ndef_mode ? `BLK_MIN : cmd.blk_count;
  // (R1) service count range
  wire         k_ok = (cmd.svc_count >= `SVC_MIN) &&
                      (cmd.svc_count <= `SVC_MAX);
  // (R3) block count range
  wire [7:0]   m_max = (cmd.svc_count > `SVC_SPLIT) ? `BLK_MAX_HI
                                                    : `BLK_MAX_LO;
  wire         m_ok  = (m_eff >= `BLK_MIN) && (m_eff <= m_max);
  // (R7) NDEF needs the NDEF system code
  wire         sys_ok = !ndef_mode || (cmd.sys_code == `NDEF_SYS_CODE);
  // (R12) (R13) attribute block count limit
  wire [15:0]  nmax_lim = attribute_info_block.enc_limit ? `NMAXB_ENC :
                          attribute_info_block.share_4b  ? `NMAXB_SHARED : `NMAXB_T3;
  wire         nmax_ok  = (cmd.mode != MODE_AIB) ||
                          (attribute_info_block.max_blocks <= nmax_lim);
  wire         cmd_ok   = k_ok && m_ok && sys_ok && nmax_ok;

  // Attribute block image
  // (R10) (R11) (R14) (R15) (R16) fixed and flag bytes
  wire [7:0]  wf_byte = cur_aib.msg_busy ? `WF_BUSY : `WF_DONE;
  wire [7:0]  rw_byte = cur_aib.writable ? `RW_RW : `RW_RO;
  // (R18) checksum of bytes 0 to 13
  wire [15:0] aib_sum = 16'(cur_aib.version) + 16'(`AIB_NBR) +
                        16'(`AIB_NBW) + 16'(cur_aib.max_blocks[15:8]) +
                        16'(cur_aib.max_blocks[7:0]) + 16'(wf_byte) +
                        16'(rw_byte) + 16'(cur_aib.msg_length[23:16]) +
                        16'(cur_aib.msg_length[15:8]) +
                        16'(cur_aib.msg_length[7:0]);
  wire [7:0]  aib_bytes [16];
  // (R9) version first
  assign aib_bytes[0]  = cur_aib.version;
  assign aib_bytes[1]  = `AIB_NBR;
  assign aib_bytes[2]  = `AIB_NBW;
  assign aib_bytes[3]  = cur_aib.max_blocks[15:8];
  assign aib_bytes[4]  = cur_aib.max_blocks[7:0];
  assign aib_bytes[5]  = 8'h00;
  assign aib_bytes[6]  = 8'h00;
  assign aib_bytes[7]  = 8'h00;
  assign aib_bytes[8]  = 8'h00;
  assign aib_bytes[9]  = wf_byte;
  assign aib_bytes[10] = rw_byte;
  // (R17) length MSB first
  assign aib_bytes[11] = cur_aib.msg_length[23:16];
  assign aib_bytes[12] = cur_aib.msg_length[15:8];
  assign aib_bytes[13] = cur_aib.msg_length[7:0];
  assign aib_bytes[14] = aib_sum[15:8];
  assign aib_bytes[15] = aib_sum[7:0];

  // (R19) empty message bytes at file start
  wire [23:0] empty_msg  = `EMPTY_MSG;
  wire [7:0]  empty_byte = (cnt == 8'h00) ? empty_msg[23:16] :
                           (cnt == 8'h01) ? empty_msg[15:8]  :
                           (cnt == 8'h02) ? empty_msg[7:0]   : 8'h00;

  // Header byte: code, identifier MSB first, service count
  wire [5:0] idm_sh_amt = 6'(8'h08 - cnt) * 6'h08;
  wire [7:0] hdr_byte = (cnt == 8'h00) ? `CMD_WRITE :
                        (cnt == `HDR_LAST) ? cur.svc_count :
                        8'(cur.idm >> idm_sh_amt);
  // (R2) same identifier for every service entry, low byte first
  wire [7:0] svc_byte = cnt[0] ? cur.svc_code[15:8] : cur.svc_code[7:0];
  // (R8) NDEF blocks are fixed, user blocks run from the first block
  wire [7:0] blk_base = (cur.mode == MODE_AIB)   ? `AIB_BLOCK  :
                        (cur.mode == MODE_EMPTY) ? `NDEF_FIRST :
                        cur.first_block;
  // (R4) two-byte entries: header then block number
  wire [7:0] list_byte = cnt[0] ? 8'(blk_base + {1'b0, cnt[7:1]})
                                : `LIST_HDR;
  wire [7:0] data_byte = (cur.mode == MODE_AIB)   ? aib_bytes[cnt[3:0]] :
                         (cur.mode == MODE_EMPTY) ? empty_byte : mem_data;
  wire [7:0] cur_byte  = (state == ST_HDR)   ? hdr_byte  :
                         (state == ST_SVC)   ? svc_byte  :
                         (state == ST_COUNT) ? cur.blk_count :
                         (state == ST_LIST)  ? list_byte : data_byte;

  // Segment length and end of segment
  // (R4) sixteen data bytes per block
  wire [7:0] seg_len = (state == ST_HDR)   ? `HDR_LEN :
                       (state == ST_SVC)   ? {cur.svc_count[6:0], 1'b0} :
                       (state == ST_COUNT) ? 8'h01 :
                       (state == ST_LIST)  ? {cur.blk_count[6:0], 1'b0} :
                                             {cur.blk_count[3:0], 4'h0};
  wire       seg_end   = (cnt == 8'(seg_len - 8'h01));
  wire       sending   = (state != ST_IDLE) && (state != ST_RESP);
  wire       slot_free = !tx_valid || tx_ready;
  wire       load      = sending && slot_free &&
                         ((state != ST_DATA) || primed);
  wire       frame_end = load && (state == ST_DATA) && seg_end;
  wire       rx_take   = (state == ST_RESP) && rx_valid;
  wire       rx_final  = rx_take && (rcnt == `RESP_LAST);
  wire       timed_out = (state == ST_RESP) && (wcnt >= 32'(TIMEOUT));

  // Next state after the current segment ends
  state_t next_state;
  assign next_state = (state == ST_HDR)   ? ST_SVC   :
                      (state == ST_SVC)   ? ST_COUNT :
                      (state == ST_COUNT) ? ST_LIST  :
                      (state == ST_LIST)  ? ST_DATA  : ST_RESP;

  // User block data store
  block_buffer #(
    .WIDTH (8),
    .DEPTH (256),
    .AW    (8)
  ) block_buffer_i (
    .clock   (clock),
    .wr_en   (buf_wr_en),
    .wr_addr (buf_wr_addr),
    .wr_data (buf_wr_data),
    .rd_addr (cnt),
    .rd_data (mem_data)
  );

  // Command latch on accept
  always_ff @(posedge clock) begin
    if (take) begin
      cur           <= cmd;
      cur.blk_count <= m_eff;
      cur_aib       <= attribute_info_block;
    end
  end

  // Sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt   <= 8'h00;
    end else if (take && cmd_ok) begin
      state <= ST_HDR;
      cnt   <= 8'h00;
    end else if (load && seg_end) begin
      state <= next_state;
      cnt   <= 8'h00;
    end else if (load) begin
      cnt   <= 8'(cnt + 8'h01);
    end else if (rx_final || timed_out) begin
      state <= ST_IDLE;
    end
  end

  // Memory read settles one cycle after the address moves
  always_ff @(posedge clock) begin
    if (rst) begin
      primed <= 1'b0;
    end else begin
      primed <= (state == ST_DATA) && !load;
    end
  end

  // Command byte output
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_seg   <= ST_IDLE;
      tx_idx   <= 8'h00;
    end else if (load) begin
      tx_valid <= 1'b1;
      tx_data  <= cur_byte;
      tx_last  <= frame_end;
      tx_seg   <= state;
      tx_idx   <= cnt;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end

  // (R6) (R20) response parse: code, identifier, two flags
  always_ff @(posedge clock) begin
    if (rst || take) begin
      rcnt     <= 4'h0;
      resp_bad <= 1'b0;
      idm_sh   <= cmd.idm;
      wcnt     <= 32'h0;
    end else if (rx_take) begin
      rcnt   <= 4'(rcnt + 4'h1);
      if (rcnt == 4'h0 && rx_data != `RSP_WRITE) begin
        resp_bad <= 1'b1;
      end
      if (rcnt != 4'h0 && rcnt <= `RESP_IDM_LAST) begin
        idm_sh <= {idm_sh[55:0], 8'h00};
        if (rx_data != idm_sh[63:56]) begin
          resp_bad <= 1'b1;
        end
      end
    end else if (state == ST_RESP) begin
      wcnt <= 32'(wcnt + 32'h1);
    end
  end

  // Status flags captured from the answer
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= '0;
    end else if (rx_take && rcnt == `RESP_FLAG1) begin
      status.flag1 <= rx_data;
    end else if (rx_take && rcnt == `RESP_FLAG2) begin
      status.flag2 <= rx_data;
    end
  end

  // User result outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      err  <= ERR_NONE;
    end else begin
      busy <= (take && cmd_ok) || (busy && !(rx_final || timed_out));
      done <= (take && !cmd_ok) || rx_final || timed_out;
      if (take && !cmd_ok) begin
        err <= ERR_PARAM;
      end else if (rx_final) begin
        err <= resp_bad ? ERR_RESP : ERR_NONE;
      end else if (timed_out) begin
        err <= ERR_TIMEOUT;
      end
    end
  end

  // Helper: data bytes accepted in the current frame
  logic [7:0] data_sent;
  always_ff @(posedge clock) begin
    if (rst || take) begin
      data_sent <= 8'h00;
    end else if (tx_valid && tx_ready && tx_seg == ST_DATA) begin
      data_sent <= 8'(data_sent + 8'h01);
    end
  end

  svc_range_a: assert property ( // (R1)
    @(posedge clock) disable iff (rst)
    take && !k_ok |=> done && err == ERR_PARAM && !busy)
    else $error("bad service count not refused");
  blk_range_a: assert property ( // (R3)
    @(posedge clock) disable iff (rst)
    take && k_ok && !m_ok |=> done && err == ERR_PARAM && !busy)
    else $error("bad block count not refused");
  svc_same_a: assert property ( // (R2)
    @(posedge clock) disable iff (rst)
    tx_valid && tx_seg == ST_SVC |->
      tx_data == (tx_idx[0] ? cur.svc_code[15:8] : cur.svc_code[7:0]))
    else $error("service identifier byte differs");
  data_len_a: assert property ( // (R4)
    @(posedge clock) disable iff (rst)
    tx_valid && tx_ready && tx_last |->
      data_sent == 8'({cur.blk_count[3:0], 4'h0} - 8'h01))
    else $error("data byte count wrong");
  ndef_sys_a: assert property ( // (R7)
    @(posedge clock) disable iff (rst)
    take && cmd.mode != MODE_USER && cmd.sys_code != `NDEF_SYS_CODE
      |=> err == ERR_PARAM ##1 !busy)
    else $error("NDEF command without NDEF system code");
  aib_zero_a: assert property ( // (R14)
    @(posedge clock) disable iff (rst)
    tx_valid && tx_seg == ST_DATA && cur.mode == MODE_AIB &&
      tx_idx >= 8'h05 && tx_idx <= 8'h08 |-> tx_data == 8'h00)
    else $error("reserved attribute byte not zero");
  aib_sum_a: assert property ( // (R18)
    @(posedge clock) disable iff (rst)
    tx_valid && tx_seg == ST_DATA && cur.mode == MODE_AIB &&
      tx_idx == 8'h0F |-> tx_data == aib_sum[7:0])
    else $error("attribute checksum low byte wrong");
  empty_msg_a: assert property ( // (R19)
    @(posedge clock) disable iff (rst)
    tx_valid && tx_seg == ST_DATA && cur.mode == MODE_EMPTY &&
      tx_idx == 8'h00 |-> tx_data == empty_msg[23:16])
    else $error("empty message marker wrong");
  resp_end_a: assert property ( // (R6)
    @(posedge clock) disable iff (rst)
    rx_final |=> done && !busy &&
      (err == (resp_bad ? ERR_RESP : ERR_NONE)))
    else $error("response end not reported");
  idm_check_a: assert property ( // (R20)
    @(posedge clock) disable iff (rst)
    rx_take && rcnt == 4'h1 && rx_data != idm_sh[63:56]
      |=> resp_bad)
    else $error("identifier mismatch not flagged");

  user_write_c:  cover property (@(posedge clock) disable iff (rst)
    rx_final && cur.mode == MODE_USER && !resp_bad);
  aib_write_c:   cover property (@(posedge clock) disable iff (rst)
    frame_end && cur.mode == MODE_AIB);
  reject_c:      cover property (@(posedge clock) disable iff (rst)
    take && !cmd_ok);
  timeout_c:     cover property (@(posedge clock) disable iff (rst)
    timed_out);
endmodule

/* File: design/tag_writer_params.svh */
// Constants for the reader-side block write controller
// Functional notes
// (R1) Service-file count must be 1 to 11, else error.
// (R2) All listed service-file identifiers must carry one identical value.
// (R3) Block count 1..12 for 1..8 services, 1..11 for 9..11.
// (R4) Reader sends 16 data bytes per listed block; entries two or three bytes.
// (R5) Tunnel mode hands write data to the tag's host, not memory.
// (R6) Response: code byte, eight-byte identifier, two status flag bytes.
// (R7) NDEF use needs the NDEF system code configured.
// (R8) Block 0 holds attributes, NDEF file spans blocks 1 to 23.
// (R9) Attribute byte 0 holds the mapping version in use.
// (R10) Attribute byte 1, blocks per read, should be 15.
// (R11) Attribute byte 2, blocks per write, should be 11.
// (R12) Max NDEF blocks at most 0x17 shared, 0x1A Type 3 only; with enc_limit also set the code allows 0x18 when shared.
// (R13) Encryption settings may limit max NDEF blocks to 0x18.
// (R14) Attribute bytes 5 to 8 are written as zero.
// (R15) Write-status byte 0x0F before message write, 0x00 after.
// (R16) Access byte: 0x00 read-only, 0x01 read and write.
// (R17) Bytes 11 to 13 hold message length, MSB first.
// (R18) Bytes 14 to 15 hold the sum of bytes 0 to 13.
// (R19) Empty message is 0xD00000 at the start of the NDEF file.
// (R20) Identifier must match the one from the polling answer.
// (R21) Tag rejects a command whose length mismatches its counts.
// (R22) Tag leaves blocks unchanged on any error answer.
`ifndef TAG_WRITER_PARAMS_SVH
`define TAG_WRITER_PARAMS_SVH
`define CMD_WRITE      8'h08
`define RSP_WRITE      8'h09
`define SVC_MIN        8'h01
`define SVC_MAX        8'h0B
`define SVC_SPLIT      8'h08
`define BLK_MIN        8'h01
`define BLK_MAX_LO     8'h0C
`define BLK_MAX_HI     8'h0B
`define HDR_LEN        8'h0A
`define HDR_LAST       8'h09
`define RESP_LAST      4'hA
`define RESP_IDM_LAST  4'h8
`define RESP_FLAG1     4'h9
`define RESP_FLAG2     4'hA
`define LIST_HDR       8'h80
`define NDEF_SYS_CODE  16'h12FC
`define AIB_BLOCK      8'h00
`define NDEF_FIRST     8'h01
`define NDEF_LAST      8'h17
`define AIB_NBR        8'h0F
`define AIB_NBW        8'h0B
`define NMAXB_SHARED   16'h0017
`define NMAXB_T3       16'h001A
`define NMAXB_ENC      16'h0018
`define WF_BUSY        8'h0F
`define WF_DONE        8'h00
`define RW_RO          8'h00
`define RW_RW          8'h01
`define EMPTY_MSG      24'hD00000
`define RESP_TIMEOUT   32'h00001000
`endif

/* File: design/tag_writer_pkg.sv */
// Types shared by the reader-side block write controller
package tag_writer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_SVC   = 3'b010,
    ST_COUNT = 3'b011,
    ST_LIST  = 3'b100,
    ST_DATA  = 3'b101,
    ST_RESP  = 3'b110
  } state_t;
  typedef enum logic [1:0] {
    MODE_USER  = 2'b00,
    MODE_AIB   = 2'b01,
    MODE_EMPTY = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    ERR_NONE    = 2'b00,
    ERR_PARAM   = 2'b01,
    ERR_RESP    = 2'b10,
    ERR_TIMEOUT = 2'b11
  } err_t;
  typedef struct packed {
    mode_t       mode;
    logic [63:0] idm;
    logic [15:0] svc_code;
    logic [15:0] sys_code;
    logic [7:0]  svc_count;
    logic [7:0]  blk_count;
    logic [7:0]  first_block;
  } cmd_t;
  typedef struct packed {
    logic [7:0]  version;
    logic [15:0] max_blocks;
    logic        msg_busy;
    logic        writable;
    logic [23:0] msg_length;
    logic        share_4b;
    logic        enc_limit;
  } aib_t;
  typedef struct packed {
    logic [7:0] flag1;
    logic [7:0] flag2;
  } status_t;
endpackage

/* File: design/block_buffer.sv */
// Byte memory holding user block data for write commands
`timescale 1ns/10ps
module block_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input  wire logic             clock,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side, data one cycle after address
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: verif/tag_model.sv */
// Behavioural tag that takes block write frames and answers them
`timescale 1ns/10ps
module tag_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Command stream from the controller
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready,
  // Response stream
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  // Own identifier, flags, {tunnel, mute, bad code, stall}
  input  wire logic [63:0] idm,
  input  wire logic [15:0] flags,
  input  wire logic [3:0]  ctl
);
  localparam logic [15:0] ERR_FLAGS = 16'hFFA1; // Arbitrary error status
  logic [7:0] q [$];
  logic [7:0] rsp [$];
  logic [7:0] mem [0:23][0:15];
  logic [7:0] host [0:23][0:15];
  int         frames = 0;
  int         gap = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Check one frame, store its data, queue the answer
  task automatic parse();
    int k, m, p, e;
    logic ok;
    logic [7:0] blk [0:11];
    k = q[9];
    m = q[10+2*k];
    ok = q[0] == 8'h08 && k >= 1 && k <= 11;
    ok &= m >= 1 && m <= (k <= 8 ? 12 : 11);
    ok &= {q[1], q[2], q[3], q[4], q[5], q[6], q[7], q[8]} == idm;
    for (e = 1; e < k; e++)
      ok &= q[10+2*e] == q[10] && q[11+2*e] == q[11];
    // block list of two or three byte entries
    p = 11 + 2 * k;
    for (e = 0; e < m && e < 12; e++) begin
      blk[e] = q[p+1];
      ok &= blk[e] <= 23;
      p += q[p][7] ? 2 : 3;
    end
    // length holds sixteen bytes a block
    ok &= q.size() == p + 16 * m;
    // store only on success, tunnel goes to host
    for (e = 0; ok && e < m * 16; e++)
      if (ctl[3]) host[blk[e/16]][e%16] = q[p+e];
      else mem[blk[e/16]][e%16] = q[p+e];
    frames++;
    if (!ctl[2]) begin
      rsp.push_back(ctl[1] ? 8'h0B : 8'h09);
      for (e = 7; e >= 0; e--) rsp.push_back(idm[8*e+:8]);
      rsp.push_back(ok ? flags[15:8] : ERR_FLAGS[15:8]);
      rsp.push_back(ok ? flags[7:0] : ERR_FLAGS[7:0]);
    end
  endtask
  // Collect bytes, answer after a gap, scramble the idle line
  always @(posedge clock) begin
    if (rst) begin
      q.delete();
      rsp.delete();
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ctl[0] ? 1'($urandom) : 1'b1;
      if (tx_valid && tx_ready) begin
        q.push_back(tx_data);
        if (tx_last) begin
          parse();
          q.delete();
          gap = ctl[0] ? 9 : 1;
        end
      end
      if (rsp.size() > 0 && gap > 0) gap--;
      else if (rsp.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data <= rsp.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule

/* File: verif/tag_writer_tb.sv */
// Self-checking bench for the block write controller
`timescale 1ns/10ps
module tag_writer_tb;
  import tag_writer_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  cmd_t        cmd = '0;
  aib_t        attribute_info_block = '0;
  logic        buf_wr_en = 1'b0;
  logic [7:0]  buf_wr_addr = 8'h00;
  logic [7:0]  buf_wr_data = 8'h00;
  logic        tx_valid, tx_last, tx_ready, rx_valid, busy, done;
  logic [7:0]  tx_data, rx_data, old;
  err_t        err;
  status_t     status;
  logic [63:0] tag_idm = 64'h0;
  logic [15:0] flags = 16'h0000;
  logic [3:0]  ctl = 4'h0;
  logic [7:0]  dat [0:191];
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          i, j, k, m, f0;
  cmd_t        c;
  aib_t        a;
  // Controller and tag
  tag_writer #(.TIMEOUT(64)) tag_writer_i (
    .clock(clock), .rst(rst), .start(start), .cmd(cmd), .attribute_info_block(attribute_info_block),
    .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
    .buf_wr_data(buf_wr_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy), .done(done), .err(err),
    .status(status));
  tag_model tag_model_i (
    .clock(clock), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .idm(tag_idm), .flags(flags), .ctl(ctl));
  // Clock and hang guard
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command: present it, hold start, wait for done
  task automatic run(input cmd_t cv, input aib_t av, input int hold);
    int n;
    n = 0;
    f0 = tag_model_i.frames;
    @(posedge clock);
    cmd <= cv;
    attribute_info_block <= av;
    start <= 1'b1;
    repeat (hold) @(posedge clock);
    start <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 3000) chk(n, 0);
    chk(busy, 0);
  endtask
  // Fill the controller's block data store
  task automatic load(input int nb);
    for (int x = 0; x < nb; x++) begin
      @(posedge clock);
      buf_wr_en <= 1'b1;
      buf_wr_addr <= 8'(x);
      buf_wr_data <= dat[x];
    end
    @(posedge clock);
    buf_wr_en <= 1'b0;
  endtask
  // Byte the tag holds, in memory or at its host
  function automatic logic [7:0] tgt(input int b, input int j);
    return ctl[3] ? tag_model_i.host[b][j] : tag_model_i.mem[b][j];
  endfunction
  // Expected attribute block byte
  function automatic logic [7:0] aib_byte(input aib_t v, input int j);
    logic [7:0]  b [0:15];
    logic [15:0] s;
    b = '{v.version, 8'h0F, 8'h0B, v.max_blocks[15:8], v.max_blocks[7:0],
          8'h00, 8'h00, 8'h00, 8'h00, v.msg_busy ? 8'h0F : 8'h00,
          8'(v.writable), v.msg_length[23:16], v.msg_length[15:8],
          v.msg_length[7:0], 8'h00, 8'h00};
    s = 16'h0000;
    for (int x = 0; x < 14; x++) s += 16'(b[x]);
    b[14] = s[15:8];
    b[15] = s[7:0];
    return b[j];
  endfunction
  // Main sequence
  initial begin
    i = $urandom(32'h0504AAF7);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk({busy, done, err, status, tx_valid, tx_last}, 0);
    tag_idm = {$urandom, $urandom};
    c = '{MODE_USER, tag_idm, 16'($urandom), 16'h12FC, 8'h01, 8'h01, 8'h01};
    // Parameter refusals
    for (i = 0; i < 9; i++) begin
      cmd_t b;
      b = c;
      a = '0;
      case (i)
        0: b.svc_count = 8'h00;
        1: b.svc_count = 8'h0C;
        2: b.blk_count = 8'h00;
        3: begin b.svc_count = 8'h08; b.blk_count = 8'h0D; end
        4: begin b.svc_count = 8'h09; b.blk_count = 8'h0C; end
        5: begin b.mode = MODE_EMPTY; b.sys_code = 16'h12FD; end
        6: begin b.mode = MODE_AIB; a.max_blocks = 16'h001B; end
        7: begin
          b.mode = MODE_AIB;
          a.share_4b = 1'b1;
          a.max_blocks = 16'h0018;
        end
        default: begin
          b.mode = MODE_AIB;
          a.enc_limit = 1'b1;
          a.max_blocks = 16'h0019;
        end
      endcase
      run(b, a, 1);
      chk(err, ERR_PARAM);
      chk(tag_model_i.frames - f0, 0);
    end
    // User writes at count limits and at random
    for (i = 0; i < 8; i++) begin
      k = i == 0 ? 8 : i == 1 ? 11 : i == 2 ? 1 : 1 + $urandom % 11;
      m = (k <= 8) ? 12 : 11;
      if (i > 2) m = 1 + $urandom % m;
      if (i == 2) m = 1;
      c.svc_count = 8'(k);
      c.blk_count = 8'(m);
      c.first_block = 8'(1 + $urandom % (24 - m));
      c.svc_code = 16'($urandom);
      for (j = 0; j < 192; j++) dat[j] = 8'($urandom);
      flags = 16'($urandom);
      ctl = {i == 3, 2'b00, i[0]};
      load(16 * m);
      run(c, a, 3);
      chk(err, ERR_NONE);
      chk(status, flags);
      chk(tag_model_i.frames - f0, 1);
      for (j = 0; j < 16 * m; j++)
        chk(tgt(c.first_block + j / 16, j % 16), dat[j]);
    end
    // Attribute block at the three block count ceilings
    ctl = 4'h0;
    c.mode = MODE_AIB;
    for (i = 0; i < 3; i++) begin
      a = {8'($urandom), i == 0 ? 16'h0017 : i == 1 ? 16'h001A : 16'h0018,
           1'($urandom), 1'($urandom), 24'($urandom), i == 0, i == 2};
      run(c, a, 1);
      chk(err, ERR_NONE);
      for (j = 0; j < 16; j++)
        chk(tgt(0, j), aib_byte(a, j));
    end
    // Empty message
    c.mode = MODE_EMPTY;
    run(c, a, 1);
    chk(err, ERR_NONE);
    for (j = 0; j < 16; j++)
      chk(tgt(1, j), j == 0 ? 8'hD0 : 8'h00);
    // Bad code, foreign identifier, silent tag
    c.mode = MODE_USER;
    c.blk_count = 8'h01;
    for (i = 0; i < 3; i++) begin
      old = tag_model_i.mem[c.first_block][0];
      ctl = {1'b0, i == 2, i == 0, 1'b1};
      tag_idm = i == 1 ? ~c.idm : c.idm;
      dat[0] = ~old;
      load(16);
      run(c, a, 1);
      chk(err, i == 2 ? ERR_TIMEOUT : ERR_RESP);
      if (i == 1) chk(tag_model_i.mem[c.first_block][0], old);
    end
    conclude();
  end
endmodule
